// [tx_cell_port_defs.vh]
// constants for the transmit cell input port
// Behaviour
// - capture one byte per edge while enable low and not full, from the first start marker on
// - enable high ignores data and start
// - start-marked byte begins a new cell
// - almost-full low at five bytes free
// - almost-full high when a cell fits
// - outputs change on clock rising edges, and at once when reset goes low
// - reset discards every stored cell
`ifndef TX_CELL_PORT_DEFS_VH
`define TX_CELL_PORT_DEFS_VH
// ==================================================
// sizes and thresholds
`define CELL_BYTES      53
`define FIFO_CELLS      3
`define AF_SET_FREE     5
`define AF_CLR_FREE     53
`endif

// [tx_cell_fifo.v]
// flip-flop fifo storing cell bytes with a start marker bit
`timescale 1ns/10ps
`default_nettype none
module tx_cell_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 159,
  parameter AW    = 8
) (
  input  wire             i_clk_sys,
  input  wire             i_resetn,
  input  wire             i_wr,
  input  wire [WIDTH-1:0] i_wdata,
  input  wire             i_rd,
  output wire [WIDTH-1:0] o_rdata,
  output wire [AW:0]      o_count
);
  localparam [AW:0]   DEPTH_C = DEPTH;
  localparam [AW-1:0] LAST_P  = DEPTH - 1;
  localparam [AW-1:0] ONE_P   = {{(AW-1){1'b0}}, 1'b1};
  localparam [AW:0]   ONE_C   = {{AW{1'b0}}, 1'b1};
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wptr_q;
  reg [AW-1:0]    rptr_q;
  reg [AW:0]      count_q;
  wire            full  = (count_q == DEPTH_C);
  wire            empty = (count_q == {(AW+1){1'b0}});
  wire            do_wr = i_wr & ~full;
  wire            do_rd = i_rd & ~empty;
  genvar g;
  // ==================================================
  // storage
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      localparam [AW-1:0] IDX = g;
      always @(posedge i_clk_sys) begin
        if (do_wr && wptr_q == IDX) begin
          mem_q[g] <= i_wdata;
        end
      end
    end
  endgenerate
  // ==================================================
  // pointers
  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wptr_q  <= {AW{1'b0}};
      rptr_q  <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wptr_q <= (wptr_q == LAST_P) ? {AW{1'b0}} : wptr_q + ONE_P;
      end
      if (do_rd) begin
        rptr_q <= (rptr_q == LAST_P) ? {AW{1'b0}} : rptr_q + ONE_P;
      end
      if (do_wr && !do_rd) begin
        count_q <= count_q + ONE_C;
      end else if (do_rd && !do_wr) begin
        count_q <= count_q - ONE_C;
      end
    end
  end
  assign o_rdata = mem_q[rptr_q];
  assign o_count = count_q;
endmodule
`default_nettype wire

// [atm_tx_cell_input_port.v]
// transmit cell input port: byte capture, cell framing, almost-full flag
`include "tx_cell_port_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module atm_tx_cell_input_port #(
  parameter DEPTH = `CELL_BYTES * `FIFO_CELLS
) (
  input  wire       i_clk_sys,
  input  wire       i_resetn,
  input  wire [7:0] i_tx_cell_byte,
  input  wire       i_tx_write_enable_n,
  input  wire       i_tx_cell_start,
  output reg        o_tx_fifo_almost_full_n,
  input  wire       i_drain_ready,
  output reg        o_drain_valid,
  output reg  [7:0] o_drain_byte,
  output reg        o_drain_start
);
  // ==================================================
  // sizes and thresholds
  localparam AW = 8;
  localparam [AW:0] DEPTH_W  = DEPTH;
  localparam [AW:0] SET_FREE = `AF_SET_FREE;
  localparam [AW:0] CLR_FREE = `AF_CLR_FREE;
  localparam [AW:0] ZERO_W   = {(AW+1){1'b0}};
  localparam [AW:0] ONE_W    = {{AW{1'b0}}, 1'b1};
  localparam ST_HUNT = 1'b0;
  localparam ST_CELL = 1'b1;

  // ==================================================
  // internal signals
  // framing
  reg         state_q;
  reg         state_d;
  wire        wr_take;
  wire        wr_start;
  reg         accept;
  wire        room;
  wire        push;
  // byte store
  wire [8:0]  rdata;
  wire [AW:0] count;
  wire        have;
  reg         rd;
  wire        pop;
  // drain stage next values
  reg         drain_valid_d;
  reg  [7:0]  drain_byte_d;
  reg         drain_start_d;
  // flag
  reg  [AW:0] free_now;
  reg  [AW:0] free_next;
  reg         af_n_d;

  // ==================================================
  // write side qualification
  assign wr_take  = ~i_tx_write_enable_n;
  assign wr_start = wr_take & i_tx_cell_start;
  assign have     = (count != ZERO_W);
  assign room     = (count != DEPTH_W);
  // a byte offered while full is lost; it must not move the free count
  assign push     = accept & room;
  assign pop      = o_drain_valid & i_drain_ready;

  // ==================================================
  // cell framing
  always @* begin
    accept  = 1'b0;
    state_d = state_q;
    case (state_q)
      ST_HUNT: begin
        // bytes before the first start marker are dropped
        accept = wr_start;
        if (wr_start) begin
          state_d = ST_CELL;
        end
      end
      ST_CELL: begin
        // a later start marker realigns through the stored mark bit
        accept = wr_take;
      end
      default: begin
        accept  = 1'b0;
        state_d = ST_HUNT;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_HUNT;
    end else begin
      state_q <= state_d;
    end
  end

  // ==================================================
  // byte store, start mark kept beside each byte
  tx_cell_fifo #(
    .WIDTH (9),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_wr      (push),
    .i_wdata   ({wr_start, i_tx_cell_byte}),
    .i_rd      (rd),
    .o_rdata   (rdata),
    .o_count   (count)
  );

  // ==================================================
  // drain stage: refill when empty or being taken
  always @* begin
    rd = have & (~o_drain_valid | pop);
  end

  always @* begin
    drain_valid_d = o_drain_valid;
    drain_byte_d  = o_drain_byte;
    drain_start_d = o_drain_start;
    if (rd) begin
      drain_valid_d = 1'b1;
      drain_byte_d  = rdata[7:0];
      drain_start_d = rdata[8];
    end else if (pop) begin
      drain_valid_d = 1'b0;
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_drain_valid <= 1'b0;
    end else begin
      o_drain_valid <= drain_valid_d;
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_drain_byte  <= 8'h00;
      o_drain_start <= 1'b0;
    end else begin
      o_drain_byte  <= drain_byte_d;
      o_drain_start <= drain_start_d;
    end
  end

  // ==================================================
  // free space as it stands after this edge
  always @* begin
    free_now  = DEPTH_W - count;
    free_next = free_now;
    case ({push, rd})
      2'b10:   free_next = free_now - ONE_W;
      2'b01:   free_next = free_now + ONE_W;
      default: free_next = free_now;
    endcase
  end

  // ==================================================
  // almost-full flag with hysteresis
  // between the two thresholds the flag keeps its last level
  always @* begin
    af_n_d = o_tx_fifo_almost_full_n;
    if (free_next <= SET_FREE) begin
      af_n_d = 1'b0;
    end else if (free_next >= CLR_FREE) begin
      af_n_d = 1'b1;
    end
  end

  always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tx_fifo_almost_full_n <= 1'b1;
    end else begin
      o_tx_fifo_almost_full_n <= af_n_d;
    end
  end
endmodule
`default_nettype wire

// [tx_port_chk.sv]
// assertions on the transmit cell input port
`timescale 1ns/10ps
`default_nettype none
module tx_port_chk (
  input wire       i_clk_sys, i_resetn, i_tx_write_enable_n, i_tx_cell_start, i_drain_ready,
  input wire       o_tx_fifo_almost_full_n, o_drain_valid, o_drain_start,
  input wire [7:0] o_drain_byte
);
  wire af = o_tx_fifo_almost_full_n;
  wire wr = !i_tx_write_enable_n;
  wire dv = o_drain_valid;
  wire tk = dv && i_drain_ready;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  a_reset_empty: assert property ($rose(i_resetn) |-> af ##1 !dv) else $error("reset");
  a_drain_hold: assert property (dv && !i_drain_ready |=> $stable({dv, o_drain_byte}))
    else $error("hold");
  a_start_first: assert property (wr && i_tx_cell_start && !dv && $past(!wr && !dv)
    && $past(!wr, 2) |-> ##[1:2] dv && o_drain_start) else $error("start");
  a_fall_write: assert property ($fell(af) |-> $past(wr)) else $error("fall");
  a_rise_read: assert property ($rose(af) |-> $past(tk) || $past(tk, 2)) else $error("rise");
  a_idle_keeps: assert property (!wr && af |=> af) else $error("idle");
  a_low_holds: assert property (!af && dv && !i_drain_ready |=> !af) else $error("low");
  a_idle_empty: assert property (!wr && !dv && $past(!wr && !dv) |=> !dv) else $error("empty");
endmodule
bind atm_tx_cell_input_port tx_port_chk CHK (.*);
`default_nettype wire

// [tx_cell_source.sv]
// upstream cell source model
`timescale 1ns/10ps
`default_nettype none
module tx_cell_source (
  input  wire        i_clk_sys, i_af_n,
  output logic [7:0] o_byte,
  output logic       o_wen_n, o_start
);
  initial {o_wen_n, o_start, o_byte} = 10'h200;
  // idle cycles carry junk data and a stray start
  task put(input logic [7:0] b, input logic s, idle);
    @(negedge i_clk_sys);
    while (s && !i_af_n) @(negedge i_clk_sys);
    o_wen_n = idle;
    o_start = s | idle;
    o_byte = idle ? ~o_byte : b;
  endtask
endmodule
`default_nettype wire

// [atm_tx_cell_input_port_bench.sv]
// testbench for the transmit cell input port
`timescale 1ns/10ps
`default_nettype none
module atm_tx_cell_input_port_bench;
  logic       i_clk_sys = 0, i_resetn = 0, i_drain_ready = 0, go = 0;
  wire  [7:0] i_tx_cell_byte, o_drain_byte;
  wire        i_tx_write_enable_n, i_tx_cell_start, o_drain_valid, o_drain_start;
  wire        o_tx_fifo_almost_full_n;
  int         errors = 0, n_tests = 0;
  logic [8:0] q[$];
  always #10 i_clk_sys = ~i_clk_sys;
  always @(negedge i_clk_sys) i_drain_ready <= go && $urandom % 2;
  atm_tx_cell_input_port DUT (.*);
  tx_cell_source SRC (.i_clk_sys, .i_af_n(o_tx_fifo_almost_full_n), .o_byte(i_tx_cell_byte),
    .o_wen_n(i_tx_write_enable_n), .o_start(i_tx_cell_start));
  task chk(input logic [8:0] s, e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task send(input int a, n);
    logic [7:0] v;
    for (int i = a; i < n; i++) begin
      v = $urandom;
      q.push_back({i == 0, v});
      SRC.put(v, i == 0, 0);
      if ($urandom % 4 == 0) SRC.put(0, 0, 1);
    end
    SRC.put(0, 0, 1);
  endtask
  task drain;
    go = 1;
    for (int k = 0; k < 2000 && q.size() > 0; k++) @(posedge i_clk_sys);
    chk(9'(q.size()), 0);
  endtask
  always @(posedge i_clk_sys)
    if (i_resetn && o_drain_valid && i_drain_ready)
      chk({o_drain_start, o_drain_byte}, q.size() ? q.pop_front() : 'x);
  initial begin
    void'($urandom(55));
    repeat (3) @(negedge i_clk_sys);
    i_resetn = 1;
    SRC.put(8'h5a, 0, 0);
    send(0, 53);
    drain;
    go = 0;
    send(0, 53);
    send(0, 53);
    send(0, 47);
    chk(o_tx_fifo_almost_full_n, 1);
    send(47, 49);
    chk(o_tx_fifo_almost_full_n, 0);
    send(49, 53);
    fork send(0, 53); drain; join
    chk(o_tx_fifo_almost_full_n, 1);
    go = 0;
    send(0, 20);
    i_resetn = 0;
    q.delete();
    @(negedge i_clk_sys) i_resetn = 1;
    chk({o_drain_valid, o_tx_fifo_almost_full_n}, 1);
    send(0, 53);
    drain;
    complete_run;
  end
  initial begin
    #100000 errors++;
    complete_run;
  end
endmodule
`default_nettype wire
